// file: maint_regs.svh
/*
 * Register offsets, field positions, limits and timing constants of the
 * maintenance counter and parameter copy block.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`ifndef MAINT_REGS_SVH
`define MAINT_REGS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define R_COPY 8'h00
`define R_OP_PRE 8'h04
`define R_OP_BASIS 8'h08
`define R_FAN_PRE 8'h0c
`define R_CAP_PRE 8'h10
`define R_RLY_PRE 8'h14
`define R_SW_PRE 8'h18
`define R_CLR 8'h1c
`define R_CONFIRM 8'h20
`define R_INIT 8'h24
`define R_OP_MON 8'h28
`define R_FAN_MON 8'h2c
`define R_FAN_MAINT 8'h30
`define R_LIFE_MON 8'h34
`define R_RUN_MON 8'h38
`define R_EN_LO 8'h3c
`define R_EN_HI 8'h40
`define R_TRACE 8'h44
`define R_HIST 8'h48
`define R_PIDX 8'h4c
`define R_PDATA 8'h50
`define R_IRQ_STAT 8'h54
`define R_IRQ_MASK 8'h58
// ------------------------------------------------------------
// Fields, limits and timing
// ------------------------------------------------------------
`define COPY_PERMIT 2
`define COPY_BUSY 8
`define COPY_ERR 9
`define CLR_FAULT 0
`define CLR_ENERGY 1
`define CLR_RUN 2
`define IRQ_DONE 0
`define IRQ_MISMATCH 1
`define IRQ_REFUSED 2
`define IRQ_DIFF 3
`define IRQ_FAULT 4
`define PRESET_MAX 14'd9999
`define LIFE_MAX 8'd150
`define HOUR_UNIT 32'd10
`define ENERGY_WRAP 10'd999
`define NPARAM 16
`define HDR_LAST 5'd1
`define CLK_HZ 64'd40000000
`define T_HOUR_S 64'd3600
`endif

// file: maint_pkg.sv
/*
 * Types of the maintenance counter and parameter copy block.
 * Assumes the constants of maint_regs.svh alongside.
 */
package maint_pkg;
    typedef enum logic [1:0] {
        CP_NONE = 2'b00,
        CP_TO_KEYPAD = 2'b01,
        CP_TO_DRIVE = 2'b10,
        CP_COMPARE = 2'b11
    } copy_sel_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_XFER = 2'b10
    } copy_st_t;
endpackage : maint_pkg

// file: maint_counter_params.sv
/*
 * Maintenance counters, life monitors, clear commands and the parameter
 * copy engine towards a detachable keypad, behind a Wishbone slave.
 * Assumes one 40 MHz clock, synchronous inputs, and a keypad that answers
 * each held request with a one-cycle ack.
 */
// How it works
// - Selector 1 copies every drive parameter into keypad storage.
// - Selector 2 copies every keypad parameter into the drive.
// - Selector 3 compares both sets and changes neither.
// - Model code or firmware number mismatch aborts a copy with error.
// - Copy refused unless permit bit is one; permit resets to zero.
// - Operation-time counter loads preset 0..9999 times ten hours.
// - Basis zero counts every powered hour.
// - Basis one counts only with run command or output voltage.
// - Fan counter loads preset times ten; also the maintenance base.
// - Capacitor life monitor preset 0..150 percent, default zero.
// - Pre-charge relay life monitor preset 0..150 percent.
// - Power-switch life monitor preset 0..150 percent.
// - General initialization leaves fault trace and history alone.
// - Fault-log clear plus confirm erases logs, setting reads zero.
// - Energy counters survive power cycles and general initialization.
// - Energy clear plus confirm zeroes both monitors, reads zero.
// - Run-command counter survives power cycles and initialization.
// - Run clear plus confirm zeroes the run count, reads zero.
`include "maint_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module maint_counter_params
    import maint_pkg::*;
#(
    parameter longint HOUR_CYCLES = `CLK_HZ * `T_HOUR_S
) (
    input wire logic i_clk, // 40 MHz clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_wb_cyc, // Wishbone cycle
    input wire logic i_wb_stb, // Wishbone strobe
    input wire logic i_wb_we, // Wishbone write
    input wire logic [7:0] i_wb_adr, // Byte address
    input wire logic [31:0] i_wb_dat, // Write data
    input wire logic [3:0] i_wb_sel, // Byte lanes
    output logic [31:0] o_wb_dat, // Read data
    output logic o_wb_ack, // Acknowledge
    output logic o_irq, // Level interrupt
    output logic o_kp_req, // Keypad access request
    output logic o_kp_we, // Keypad access is a write
    output logic [4:0] o_kp_addr, // Keypad word address
    output logic [15:0] o_kp_wdata, // Keypad write data
    input wire logic i_kp_ack, // Keypad answer pulse
    input wire logic [15:0] i_kp_rdata, // Keypad read data
    input wire logic [15:0] i_model_code, // Drive model code
    input wire logic [15:0] i_fw_number, // Firmware number
    input wire logic i_run_cmd, // Run command active
    input wire logic i_volt_out, // Output voltage present
    input wire logic i_fan_on, // Cooling fan running
    input wire logic [2:0] i_wear_tick, // Life +1%: cap, relay, switch
    input wire logic i_kwh_pulse, // One energy unit consumed
    input wire logic i_fault_valid, // Fault occurred pulse
    input wire logic [7:0] i_fault_code // Fault code
);
    // ------------------------------------------------------------
    // Helpers and declarations
    // ------------------------------------------------------------
    function automatic logic [13:0] clamp_pre(input logic [31:0] d);
        return (d > 32'(`PRESET_MAX)) ? `PRESET_MAX : d[13:0];
    endfunction : clamp_pre
    function automatic logic [31:0] hours(input logic [13:0] p);
        return 32'(p) * `HOUR_UNIT;
    endfunction : hours
    function automatic logic [7:0] clamp_life(input logic [31:0] d);
        return (d > 32'(`LIFE_MAX)) ? `LIFE_MAX : d[7:0];
    endfunction : clamp_life

    localparam logic [37:0] HOUR_LAST = 38'(HOUR_CYCLES - 1);
    logic ack_q, irq_q, permit_q, basis_q, err_q, diff_q, run_d_q;
    logic [1:0] sel_q;
    copy_st_t st_q;
    logic [4:0] idx_q, pidx_q, stat_q, mask_q;
    logic [2:0] pend_q;
    logic [13:0] op_pre_q, fan_pre_q;
    logic [7:0] cap_pre_q, rly_pre_q, sw_pre_q, cap_q, rly_q, sw_q;
    logic [31:0] rdat_q, op_q, fan_q, run_q, en_hi_q, trace_q, hist_q;
    logic [9:0] en_lo_q;
    logic [37:0] op_pre_cnt_q, fan_pre_cnt_q;
    logic kp_req_q, kp_we_q;
    logic [4:0] kp_addr_q;
    logic [15:0] kp_wdata_q;
    logic [15:0] mem [`NPARAM];

    logic req, wr, start, refuse, confirm, init, op_en, hit;
    logic hdr_bad, last, ev_done, ev_diff;
    logic [4:0] ev;
    assign req = i_wb_cyc && i_wb_stb && !ack_q;
    // Partial-lane writes are ignored: every register is one whole word
    assign wr = req && i_wb_we && (i_wb_sel == 4'hf);
    assign hit = wr && (i_wb_adr == `R_COPY);
    assign start = hit && (i_wb_dat[1:0] != 2'b00) && permit_q
                   && (st_q == ST_IDLE);
    assign refuse = hit && (i_wb_dat[1:0] != 2'b00) && !permit_q;
    assign confirm = wr && (i_wb_adr == `R_CONFIRM) && i_wb_dat[0];
    assign init = wr && (i_wb_adr == `R_INIT) && i_wb_dat[0];
    assign op_en = !basis_q || i_run_cmd || i_volt_out;
    assign hdr_bad = (idx_q == 5'd0) ? (i_kp_rdata != i_model_code)
                                     : (i_kp_rdata != i_fw_number);
    assign last = (idx_q == 5'(`NPARAM - 1));
    assign ev_done = kp_req_q && i_kp_ack && (st_q == ST_XFER) && last;
    assign ev_diff = kp_req_q && i_kp_ack && (st_q == ST_XFER)
                     && (sel_q == CP_COMPARE)
                     && (i_kp_rdata != mem[idx_q[3:0]]);

    // ------------------------------------------------------------
    // Wishbone slave: ack one cycle after the request, registered data
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Read mux; unmapped offsets read zero
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdat_q <= 32'h0000_0000;
        end else if (req) begin
            case (i_wb_adr)
                `R_COPY: rdat_q <= {22'h0, err_q, st_q != ST_IDLE, 5'h0,
                                    permit_q, sel_q};
                `R_OP_PRE: rdat_q <= {18'h0, op_pre_q};
                `R_OP_BASIS: rdat_q <= {31'h0, basis_q};
                `R_FAN_PRE: rdat_q <= {18'h0, fan_pre_q};
                `R_CAP_PRE: rdat_q <= {24'h0, cap_pre_q};
                `R_RLY_PRE: rdat_q <= {24'h0, rly_pre_q};
                `R_SW_PRE: rdat_q <= {24'h0, sw_pre_q};
                `R_CLR: rdat_q <= {29'h0, pend_q};
                `R_OP_MON: rdat_q <= op_q;
                `R_FAN_MON: rdat_q <= fan_q;
                `R_FAN_MAINT: rdat_q <= hours(fan_pre_q);
                `R_LIFE_MON: rdat_q <= {8'h0, sw_q, rly_q, cap_q};
                `R_RUN_MON: rdat_q <= run_q;
                `R_EN_LO: rdat_q <= {22'h0, en_lo_q};
                `R_EN_HI: rdat_q <= en_hi_q;
                `R_TRACE: rdat_q <= trace_q;
                `R_HIST: rdat_q <= hist_q;
                `R_PIDX: rdat_q <= {27'h0, pidx_q};
                `R_PDATA: rdat_q <= {16'h0, mem[pidx_q[3:0]]};
                `R_IRQ_STAT: rdat_q <= {27'h0, stat_q};
                `R_IRQ_MASK: rdat_q <= {27'h0, mask_q};
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Settings; general init restores them and spares all counters
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n || init) begin
            permit_q <= 1'b0;
            basis_q <= 1'b0;
            op_pre_q <= 14'h0000;
            fan_pre_q <= 14'h0000;
            cap_pre_q <= 8'h00;
            rly_pre_q <= 8'h00;
            sw_pre_q <= 8'h00;
            pidx_q <= 5'h00;
            mask_q <= 5'h00;
        end else if (wr) begin
            case (i_wb_adr)
                `R_COPY: permit_q <= i_wb_dat[`COPY_PERMIT];
                `R_OP_BASIS: basis_q <= i_wb_dat[0];
                `R_OP_PRE: op_pre_q <= clamp_pre(i_wb_dat);
                `R_FAN_PRE: fan_pre_q <= clamp_pre(i_wb_dat);
                `R_CAP_PRE: cap_pre_q <= clamp_life(i_wb_dat);
                `R_RLY_PRE: rly_pre_q <= clamp_life(i_wb_dat);
                `R_SW_PRE: sw_pre_q <= clamp_life(i_wb_dat);
                `R_PIDX: pidx_q <= {1'b0, i_wb_dat[3:0]};
                `R_IRQ_MASK: mask_q <= i_wb_dat[4:0];
                default: ;
            endcase
        end
    end

    // Clear commands wait for a confirm, then read back zero
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_q <= 3'h0;
        end else if (confirm) begin
            pend_q <= 3'h0;
        end else if (wr && (i_wb_adr == `R_CLR)) begin
            pend_q <= i_wb_dat[2:0];
        end
    end

    // ------------------------------------------------------------
    // Copy engine: header check, then one keypad access per parameter
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= ST_IDLE;
            sel_q <= 2'b00;
            idx_q <= 5'h00;
            err_q <= 1'b0;
            kp_req_q <= 1'b0;
            kp_we_q <= 1'b0;
            kp_addr_q <= 5'h00;
            kp_wdata_q <= 16'h0000;
        end else if (start) begin
            st_q <= ST_HDR;
            sel_q <= i_wb_dat[1:0];
            idx_q <= 5'h00;
            err_q <= 1'b0;
        end else if (kp_req_q && i_kp_ack) begin
            kp_req_q <= 1'b0;
            if (st_q == ST_HDR && hdr_bad) begin
                st_q <= ST_IDLE;
                sel_q <= 2'b00;
                err_q <= 1'b1;
            end else if (st_q == ST_HDR) begin
                st_q <= (idx_q == `HDR_LAST) ? ST_XFER : ST_HDR;
                idx_q <= (idx_q == `HDR_LAST) ? 5'h00 : idx_q + 5'h01;
            end else if (last) begin
                st_q <= ST_IDLE;
                sel_q <= 2'b00;
            end else begin
                idx_q <= idx_q + 5'h01;
            end
        end else if (!kp_req_q && st_q != ST_IDLE) begin
            // Request low for a cycle between accesses lets ack drop
            kp_req_q <= 1'b1;
            kp_we_q <= (st_q == ST_XFER) && (sel_q == CP_TO_KEYPAD);
            kp_addr_q <= (st_q == ST_XFER) ? idx_q + 5'd2 : idx_q;
            kp_wdata_q <= mem[idx_q[3:0]];
        end
    end

    // Parameter image: software, general init and keypad loads
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n || init) begin
            for (int i = 0; i < `NPARAM; i++) begin
                mem[i] <= 16'h0000;
            end
        end else if (kp_req_q && i_kp_ack && st_q == ST_XFER
                     && sel_q == CP_TO_DRIVE) begin
            mem[idx_q[3:0]] <= i_kp_rdata;
        end else if (wr && i_wb_adr == `R_PDATA && st_q == ST_IDLE) begin
            mem[pidx_q[3:0]] <= i_wb_dat[15:0];
        end
    end

    // ------------------------------------------------------------
    // Retained counters: no reset except on the life monitors, so init
    // touches none; only presets, confirmed clears and that reset do
    // ------------------------------------------------------------
    // Operation time
    always_ff @(posedge i_clk) begin
        if (wr && i_wb_adr == `R_OP_PRE) begin
            op_q <= hours(clamp_pre(i_wb_dat));
            op_pre_cnt_q <= 38'h0;
        end else if (op_en) begin
            op_pre_cnt_q <= (op_pre_cnt_q == HOUR_LAST) ? 38'h0
                            : op_pre_cnt_q + 38'h1;
            op_q <= op_q + 32'((op_pre_cnt_q == HOUR_LAST) ? 1 : 0);
        end
    end

    // Fan time, counted while the fan runs
    always_ff @(posedge i_clk) begin
        if (wr && i_wb_adr == `R_FAN_PRE) begin
            fan_q <= hours(clamp_pre(i_wb_dat));
            fan_pre_cnt_q <= 38'h0;
        end else if (i_fan_on) begin
            fan_pre_cnt_q <= (fan_pre_cnt_q == HOUR_LAST) ? 38'h0
                             : fan_pre_cnt_q + 38'h1;
            fan_q <= fan_q + 32'((fan_pre_cnt_q == HOUR_LAST) ? 1 : 0);
        end
    end

    // Energy, low word wraps into the high word
    always_ff @(posedge i_clk) begin
        if (confirm && pend_q[`CLR_ENERGY]) begin
            en_lo_q <= 10'h000;
            en_hi_q <= 32'h0;
        end else if (i_kwh_pulse) begin
            en_lo_q <= (en_lo_q == `ENERGY_WRAP) ? 10'h000 : en_lo_q + 10'h1;
            en_hi_q <= en_hi_q + 32'((en_lo_q == `ENERGY_WRAP) ? 1 : 0);
        end
    end

    // Run commands, counted on the rising edge
    always_ff @(posedge i_clk) begin
        run_d_q <= i_run_cmd;
        if (confirm && pend_q[`CLR_RUN]) begin
            run_q <= 32'h0;
        end else if (i_run_cmd && !run_d_q) begin
            run_q <= run_q + 32'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (confirm && pend_q[`CLR_FAULT]) begin
            hist_q <= 32'h0;
            trace_q <= 32'h0;
        end else if (i_fault_valid) begin
            hist_q <= {hist_q[23:0], i_fault_code};
            trace_q <= op_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cap_q <= 8'h00;
            rly_q <= 8'h00;
            sw_q <= 8'h00;
        end else begin
            if (wr && i_wb_adr == `R_CAP_PRE) cap_q <= clamp_life(i_wb_dat);
            else if (i_wear_tick[0] && cap_q != 8'hff) cap_q <= cap_q + 8'h1;
            if (wr && i_wb_adr == `R_RLY_PRE) rly_q <= clamp_life(i_wb_dat);
            else if (i_wear_tick[1] && rly_q != 8'hff) rly_q <= rly_q + 8'h1;
            if (wr && i_wb_adr == `R_SW_PRE) sw_q <= clamp_life(i_wb_dat);
            else if (i_wear_tick[2] && sw_q != 8'hff) sw_q <= sw_q + 8'h1;
        end
    end

    // ------------------------------------------------------------
    // Interrupts: sticky status, write one to clear, set wins
    // ------------------------------------------------------------
    assign ev = {i_fault_valid, ev_diff, refuse,
                 kp_req_q && i_kp_ack && st_q == ST_HDR && hdr_bad, ev_done};
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stat_q <= 5'h00;
            irq_q <= 1'b0;
        end else begin
            if (wr && i_wb_adr == `R_IRQ_STAT) begin
                stat_q <= (stat_q & ~i_wb_dat[4:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
            irq_q <= |(stat_q & mask_q);
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    assign o_irq = irq_q;
    assign o_kp_req = kp_req_q;
    assign o_kp_we = kp_we_q;
    assign o_kp_addr = kp_addr_q;
    assign o_kp_wdata = kp_wdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    ack_pulse_a: assert property (req |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack not a one-cycle answer");
    refuse_copy_a: assert property (refuse |=> st_q == ST_IDLE)
        else $error("copy started without permit");
    to_keypad_a: assert property (kp_req_q && st_q == ST_XFER
        && sel_q == CP_TO_KEYPAD |-> kp_we_q && kp_addr_q == idx_q + 5'd2)
        else $error("drive to keypad copy not writing");
    no_write_a: assert property (kp_req_q && sel_q != CP_TO_KEYPAD
        |-> !kp_we_q) else $error("keypad written outside drive copy");
    id_check_a: assert property (ev[`IRQ_MISMATCH]
        |=> st_q == ST_IDLE && err_q
        ##1 (o_irq || !$past(mask_q[`IRQ_MISMATCH])))
        else $error("identity mismatch not flagged");
    op_load_a: assert property (wr && i_wb_adr == `R_OP_PRE
        |=> op_q == hours(clamp_pre($past(i_wb_dat))))
        else $error("op time preset not scaled");
    basis_hold_a: assert property (basis_q && !i_run_cmd
        && !i_volt_out && !wr |=> $stable(op_q))
        else $error("op time counted while idle");
    life_clamp_a: assert property (wr && i_wb_adr == `R_CAP_PRE
        |=> cap_q <= `LIFE_MAX) else $error("life preset above limit");
    fault_clr_a: assert property (confirm && pend_q[0]
        && !i_fault_valid |=> hist_q == 32'h0 && pend_q == 3'h0)
        else $error("fault log not cleared");
    run_clr_a: assert property (confirm && pend_q[2]
        |=> run_q == 32'h0) else $error("run count not cleared");
    start_c: cover property (start ##[1:200] ev_done);
    mismatch_c: cover property (ev[`IRQ_MISMATCH]);
    refuse_c: cover property (refuse);
    energy_c: cover property (confirm && pend_q[1]);
endmodule : maint_counter_params
`default_nettype wire

// file: keypad_model.sv
/*
 * Behavioural detachable keypad: 18 words of copy storage.
 * Assumes the engine holds a request until it sees one ack pulse.
 */
`timescale 1ns/10ps
`default_nettype none
module keypad_model (
    input wire logic i_clk, // Same clock as the drive
    input wire logic i_req, // Access request
    input wire logic i_we, // Access is a write
    input wire logic [4:0] i_addr, // Word address
    input wire logic [15:0] i_wdata, // Write data
    input wire logic [3:0] i_delay, // Wait cycles before answering
    output logic o_ack, // One-cycle answer
    output logic [15:0] o_rdata // Read data, valid with ack
);
    logic [15:0] mem [0:17];
    int cnt = 0;
    // -----------------------------------------------
    // Answer after a chosen wait; data churns outside
    // -----------------------------------------------
    // Churning read data exposes a sampler that looks off the ack cycle
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack) begin
            if (cnt >= int'(i_delay)) begin
                o_ack <= 1'b1;
                cnt <= 0;
                o_rdata <= mem[i_addr];
                if (i_we) mem[i_addr] <= i_wdata;
            end else cnt <= cnt + 1;
        end
    end
endmodule : keypad_model
`default_nettype wire

// file: maintenance_counter_params_tb.sv
/*
 * Self-checking bench: Wishbone tasks, counter and copy scenarios.
 * Assumes keypad_model and a short HOUR_CYCLES of 4.
 */
`include "maint_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module maintenance_counter_params_tb;
    import maint_pkg::*;
    logic i_clk = 0, i_arst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 0, fcode = 0;
    logic [31:0] wdat = 0, q, rnd = 32'h2e2afd50, exp_p [16];
    logic [31:0] o_wb_dat;
    logic o_wb_ack, o_irq, kreq, kwe, kack, run = 0, kwh = 0, flt = 0;
    logic volt = 0, fan = 0;
    logic [4:0] kaddr;
    logic [15:0] kwd, krd, model = 16'h1234; // Arbitrary identity
    logic [3:0] kdel = 0;
    logic [2:0] wear = 0;
    int bad_count = 0, cmp_count = 0;
    maint_counter_params #(.HOUR_CYCLES(4)) i_dut (.i_clk(i_clk),
        .i_arst_n(i_arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq),
        .o_kp_req(kreq), .o_kp_we(kwe), .o_kp_addr(kaddr),
        .o_kp_wdata(kwd), .i_kp_ack(kack), .i_kp_rdata(krd),
        .i_model_code(model), .i_fw_number(16'h0042), .i_run_cmd(run),
        .i_volt_out(volt), .i_fan_on(fan), .i_wear_tick(wear),
        .i_kwh_pulse(kwh), .i_fault_valid(flt), .i_fault_code(fcode));
    keypad_model kp (.i_clk(i_clk), .i_req(kreq), .i_we(kwe),
        .i_addr(kaddr), .i_wdata(kwd), .i_delay(kdel), .o_ack(kack),
        .o_rdata(krd));
    // ------------------------------------------------
    // Clock, random source, check and closing tasks
    // ------------------------------------------------
    initial forever #12.5 i_clk = ~i_clk;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // One classic cycle; waits for ack, then idles one cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do begin @(posedge i_clk); n++; end
        while (o_wb_ack !== 1'b1 && n < 200);
        // A bus that never answers counts against the run
        if (o_wb_ack !== 1'b1) bad_count++;
        q = o_wb_dat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge i_clk);
    endtask : wb
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] m, e);
        wb(0, a, 0);
        chk(nm, q & m, e);
    endtask : rdc
    task automatic copy_run(input logic [31:0] cmd);
        int n;
        rnd = nxt(rnd);
        kdel <= rnd[3:0];
        wb(1, `R_COPY, cmd);
        n = 0;
        do begin wb(0, `R_COPY, 0); n++; end while (q[8] && n < 300);
        if (q[8]) bad_count++;
    endtask : copy_run
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        tally_and_finish();
    end
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    initial begin
        kp.mem[0] = 16'h1234;
        kp.mem[1] = 16'h0042;
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        rdc("permit", `R_COPY, 32'h4, 0);
        rdc("life", `R_LIFE_MON, ~0, 0);
        wb(1, `R_OP_PRE, 30);
        repeat (7) @(posedge i_clk);
        rdc("op0", `R_OP_MON, ~0, 302);
        wb(1, `R_OP_PRE, 10000);
        rdc("opmax", `R_OP_MON, ~0, 99990);
        wb(1, `R_OP_BASIS, 1);
        wb(1, `R_OP_PRE, 30);
        repeat (7) @(posedge i_clk);
        rdc("op1idle", `R_OP_MON, ~0, 300);
        run <= 1'b1;
        wb(1, `R_OP_PRE, 30);
        repeat (7) @(posedge i_clk);
        rdc("op1run", `R_OP_MON, ~0, 302);
        run <= 1'b0;
        volt <= 1'b1;
        wb(1, `R_OP_PRE, 30);
        repeat (7) @(posedge i_clk);
        rdc("op1volt", `R_OP_MON, ~0, 302);
        volt <= 1'b0;
        fan <= 1'b1;
        wb(1, `R_FAN_PRE, 30);
        repeat (7) @(posedge i_clk);
        rdc("fan", `R_FAN_MON, ~0, 302);
        fan <= 1'b0;
        rdc("fanbase", `R_FAN_MAINT, ~0, 300);
        wb(1, `R_CAP_PRE, 150);
        wb(1, `R_RLY_PRE, 200);
        wb(1, `R_SW_PRE, 7);
        wear <= 3'b001;
        @(posedge i_clk);
        wear <= 3'b000;
        rdc("lifeall", `R_LIFE_MON, ~0, 32'h00_07_96_97);
        $display("test counters done");
        wb(1, `R_CLR, 7);
        wb(1, `R_CONFIRM, 1);
        rdc("clrset", `R_CLR, 7, 0);
        rdc("runcnt", `R_RUN_MON, ~0, 0);
        run <= 1'b1;
        @(posedge i_clk);
        run <= 1'b0;
        rdc("runone", `R_RUN_MON, ~0, 1);
        kwh <= 1'b1;
        repeat (3) @(posedge i_clk);
        kwh <= 1'b0;
        fcode <= 8'h5a;
        flt <= 1'b1;
        @(posedge i_clk);
        flt <= 1'b0;
        wb(1, `R_IRQ_MASK, 32'h10);
        chk("irq", {31'h0, o_irq}, 1);
        wb(1, `R_IRQ_STAT, 32'h1f);
        chk("irqclr", {31'h0, o_irq}, 0);
        rdc("stat0", `R_IRQ_STAT, ~0, 0);
        wb(1, `R_INIT, 1);
        rdc("hist", `R_HIST, 32'hff, 32'h5a);
        rdc("energy", `R_EN_LO, ~0, 3);
        rdc("runkeep", `R_RUN_MON, ~0, 1);
        wb(1, `R_CLR, 3);
        wb(1, `R_CONFIRM, 1);
        rdc("hist0", `R_HIST, ~0, 0);
        rdc("trace0", `R_TRACE, ~0, 0);
        rdc("en0", `R_EN_LO, ~0, 0);
        $display("test clears done");
        copy_run(1);
        rdc("refused", `R_IRQ_STAT, 4, 4);
        for (int i = 0; i < 16; i++) begin
            rnd = nxt(rnd);
            exp_p[i] = {16'h0, rnd[15:0]};
            wb(1, `R_PIDX, i);
            wb(1, `R_PDATA, exp_p[i]);
        end
        wb(1, `R_COPY, 4);
        copy_run(5);
        for (int i = 0; i < 16; i++) begin
            chk("kp", kp.mem[i + 2], exp_p[i]);
        end
        rdc("done", `R_IRQ_STAT, 1, 1);
        kp.mem[5] = ~kp.mem[5];
        exp_p[3] = {16'h0, kp.mem[5]};
        copy_run(7);
        rdc("diff", `R_IRQ_STAT, 8, 8);
        chk("kpkeep", kp.mem[5], exp_p[3]);
        wb(1, `R_PIDX, 3);
        rdc("drvkeep", `R_PDATA, 32'hffff, ~exp_p[3] & 32'hffff);
        copy_run(6);
        wb(1, `R_PIDX, 3);
        rdc("todrive", `R_PDATA, 32'hffff, exp_p[3]);
        wb(1, `R_INIT, 1);
        rdc("perm0", `R_COPY, 4, 0);
        model <= 16'h4321;
        wb(1, `R_COPY, 4);
        copy_run(5);
        rdc("iderr", `R_COPY, 32'h200, 32'h200);
        rdc("idirq", `R_IRQ_STAT, 2, 2);
        $display("test copy done");
        tally_and_finish();
    end
endmodule : maintenance_counter_params_tb
`default_nettype wire
